// ---- core/timer3_control_logic.sv ----
`timescale 1ns/100ps
module timer3_control_logic (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic [7:0] i_sfr_addr, // Register address
  input wire logic i_sfr_write, // Write strobe, one cycle
  input wire logic [7:0] i_sfr_wdata, // Write data
  output logic [7:0] o_sfr_rdata, // Read data, one cycle late
  input wire logic i_timer_irq_enable, // Timer interrupt enable from core
  input wire logic i_high_byte_system_clock_select, // High byte runs on system clock, in split mode only
  input wire logic i_low_byte_system_clock_select, // Low byte runs on system clock
  input wire logic i_ext_osc, // External oscillator, asynchronous
  input wire logic i_rtc_osc, // Real-time-clock oscillator, asynchronous
  output logic o_timer_irq // Interrupt request level
);
  import timer3_pkg::*;

  // Registers
  logic [7:0] control_ff, nxt_control; // Control and status register
  logic [7:0] reload_low_ff, nxt_reload_low; // Reload low byte
  logic [7:0] reload_high_ff, nxt_reload_high; // Reload high byte
  logic [7:0] count_low_ff, nxt_count_low; // Count low byte
  logic [7:0] count_high_ff, nxt_count_high; // Count high byte
  logic [7:0] rdata_ff, nxt_rdata; // Registered read data
  logic [3:0] sys_div_ff, nxt_sys_div; // System clock divide by 12
  logic [2:0] ext_div_ff, nxt_ext_div; // External edge divide by 8
  // Synchronisers; first stage feeds only second stage
  logic ext_sync1_ff, ext_sync2_ff, ext_prev_ff;
  logic rtc_sync1_ff, rtc_sync2_ff, rtc_prev_ff;

  // Decoded events
  logic sys_div_tick; // One cycle in twelve
  logic ext_rise; // Synchronised external rising edge
  logic ext_div_tick; // Every eighth external edge
  logic rtc_rise; // Synchronised rtc rising edge
  logic alt_tick; // Selected alternate count clock
  logic capture_tick; // Selected capture trigger
  logic low_tick; // Low byte (or 16-bit) count enable
  logic high_tick; // High byte count enable in split mode
  logic low_wrap; // Low byte rolls over this cycle
  logic high_wrap; // High byte rolls over this cycle
  logic wr_control, wr_rl_low, wr_rl_high, wr_cnt_low, wr_cnt_high;

  // Field views
  logic high_flag, low_flag, low_irq_en, capture_en, split_sel, run_ctl;
  logic [1:0] alt_sel;
  assign high_flag = control_ff[BIT_HIGH_FLAG];
  assign low_flag = control_ff[BIT_LOW_FLAG];
  assign low_irq_en = control_ff[BIT_LOW_IRQ_EN];
  assign capture_en = control_ff[BIT_CAPTURE_EN];
  assign split_sel = control_ff[BIT_SPLIT];
  assign run_ctl = control_ff[BIT_RUN];
  assign alt_sel = control_ff[BIT_ALT_MSB:BIT_ALT_LSB];

  // Address decode
  always_comb begin
    wr_control = 1'b0;
    wr_rl_low = 1'b0;
    wr_rl_high = 1'b0;
    wr_cnt_low = 1'b0;
    wr_cnt_high = 1'b0;
    if (i_sfr_addr == ADDR_CONTROL_STATUS) begin
      wr_control = i_sfr_write;
    end else if (i_sfr_addr == ADDR_RELOAD_LOW) begin
      wr_rl_low = i_sfr_write;
    end else if (i_sfr_addr == ADDR_RELOAD_HIGH) begin
      wr_rl_high = i_sfr_write;
    end else if (i_sfr_addr == ADDR_COUNT_LOW) begin
      wr_cnt_low = i_sfr_write;
    end else if (i_sfr_addr == ADDR_COUNT_HIGH) begin
      wr_cnt_high = i_sfr_write;
    end
  end

  // Source edges, taken only from second stage onward
  assign ext_rise = ext_sync2_ff & ~ext_prev_ff;
  assign rtc_rise = rtc_sync2_ff & ~rtc_prev_ff;
  assign sys_div_tick = (sys_div_ff == SYS_DIV_LAST);
  assign ext_div_tick = ext_rise & (ext_div_ff == EXT_DIV_LAST);

  // Prescalers next values
  always_comb begin
    nxt_sys_div = sys_div_tick ? 4'h0 : sys_div_ff + 4'h1;
    nxt_ext_div = ext_rise ? ext_div_ff + 3'h1 : ext_div_ff;
  end

  // Alternate clock and capture trigger; reserved code gives neither
  always_comb begin
    alt_tick = 1'b0;
    capture_tick = 1'b0;
    case (alt_sel)
      ALT_SYS_DIV: begin
        alt_tick = sys_div_tick;
        capture_tick = rtc_rise;
      end
      ALT_EXT_DIV: begin
        alt_tick = ext_div_tick;
        capture_tick = ext_div_tick;
      end
      ALT_RTC: begin
        alt_tick = rtc_rise;
        capture_tick = ext_div_tick;
      end
      default: begin
        alt_tick = 1'b0;
        capture_tick = 1'b0;
      end
    endcase
  end

  // Per-byte clock choice; one alternate source serves both bytes
  always_comb begin
    low_tick = i_low_byte_system_clock_select | alt_tick;
    high_tick = i_high_byte_system_clock_select | alt_tick;
    if (split_sel) begin
      high_tick = high_tick & run_ctl;
    end else begin
      low_tick = low_tick & run_ctl;
    end
    low_wrap = low_tick & (count_low_ff == BYTE_MAX);
    if (split_sel) begin
      high_wrap = high_tick & (count_high_ff == BYTE_MAX);
    end else begin
      high_wrap = low_wrap & (count_high_ff == BYTE_MAX);
    end
  end

  // Counter, reload, flags and control next values
  always_comb begin
    nxt_count_low = count_low_ff;
    nxt_count_high = count_high_ff;
    nxt_reload_low = reload_low_ff;
    nxt_reload_high = reload_high_ff;
    nxt_control = control_ff;
    if (split_sel) begin
      // Two independent 8-bit auto-reload timers
      if (low_tick) begin
        nxt_count_low = low_wrap ? reload_low_ff : count_low_ff + 8'h01;
      end
      if (high_tick) begin
        nxt_count_high = high_wrap ? reload_high_ff : count_high_ff + 8'h01;
      end
    end else if (low_tick) begin
      if (high_wrap && !capture_en) begin
        // Full 16-bit wrap reloads both bytes
        nxt_count_low = reload_low_ff;
        nxt_count_high = reload_high_ff;
      end else begin
        // Capture mode counts freely and wraps to zero
        nxt_count_low = count_low_ff + 8'h01;
        nxt_count_high = low_wrap ? count_high_ff + 8'h01 : count_high_ff;
      end
    end
    // Capture replaces auto-reload; it acts only while split is zero
    if (capture_en && !split_sel && capture_tick) begin
      nxt_reload_low = count_low_ff;
      nxt_reload_high = count_high_ff;
    end
    // Software writes to reload and count override the hardware update of that cycle
    if (wr_rl_low) begin
      nxt_reload_low = i_sfr_wdata;
    end
    if (wr_rl_high) begin
      nxt_reload_high = i_sfr_wdata;
    end
    if (wr_cnt_low) begin
      nxt_count_low = i_sfr_wdata;
    end
    if (wr_cnt_high) begin
      nxt_count_high = i_sfr_wdata;
    end
    if (wr_control) begin
      // Writing zero is the only way a flag clears
      nxt_control = i_sfr_wdata;
    end
    // Hardware set wins over a clearing write in the same cycle
    if (high_wrap || (capture_en && !split_sel && capture_tick)) begin
      nxt_control[BIT_HIGH_FLAG] = 1'b1;
    end
    if (low_wrap) begin
      nxt_control[BIT_LOW_FLAG] = 1'b1;
    end
  end

  // Read mux, registered so data comes from a flip-flop
  always_comb begin
    if (i_sfr_addr == ADDR_CONTROL_STATUS) begin
      nxt_rdata = control_ff;
    end else if (i_sfr_addr == ADDR_RELOAD_LOW) begin
      nxt_rdata = reload_low_ff;
    end else if (i_sfr_addr == ADDR_RELOAD_HIGH) begin
      nxt_rdata = reload_high_ff;
    end else if (i_sfr_addr == ADDR_COUNT_LOW) begin
      nxt_rdata = count_low_ff;
    end else if (i_sfr_addr == ADDR_COUNT_HIGH) begin
      nxt_rdata = count_high_ff;
    end else begin
      nxt_rdata = READ_UNMAPPED;
    end
  end

  // Interrupt is a level while the high flag or an enabled low flag is pending; flags never self-clear
  assign o_timer_irq = i_timer_irq_enable & (high_flag | (low_irq_en & low_flag));
  assign o_sfr_rdata = rdata_ff;

  // Synchronisers and edge history
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ext_sync1_ff <= 1'b0;
      ext_sync2_ff <= 1'b0;
      ext_prev_ff <= 1'b0;
      rtc_sync1_ff <= 1'b0;
      rtc_sync2_ff <= 1'b0;
      rtc_prev_ff <= 1'b0;
    end else begin
      ext_sync1_ff <= i_ext_osc;
      ext_sync2_ff <= ext_sync1_ff;
      ext_prev_ff <= ext_sync2_ff;
      rtc_sync1_ff <= i_rtc_osc;
      rtc_sync2_ff <= rtc_sync1_ff;
      rtc_prev_ff <= rtc_sync2_ff;
    end
  end

  // State registers
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      control_ff <= CONTROL_RESET;
      reload_low_ff <= BYTE_RESET;
      reload_high_ff <= BYTE_RESET;
      count_low_ff <= BYTE_RESET;
      count_high_ff <= BYTE_RESET;
      rdata_ff <= READ_UNMAPPED;
      sys_div_ff <= 4'h0;
      ext_div_ff <= 3'h0;
    end else begin
      control_ff <= nxt_control;
      reload_low_ff <= nxt_reload_low;
      reload_high_ff <= nxt_reload_high;
      count_low_ff <= nxt_count_low;
      count_high_ff <= nxt_count_high;
      rdata_ff <= nxt_rdata;
      sys_div_ff <= nxt_sys_div;
      ext_div_ff <= nxt_ext_div;
    end
  end
endmodule

// ---- core/timer3_pkg.sv ----
package timer3_pkg;
  // Register addresses on the special function register bus
  localparam logic [7:0] ADDR_CONTROL_STATUS = 8'h91;
  localparam logic [7:0] ADDR_RELOAD_LOW = 8'h92;
  localparam logic [7:0] ADDR_RELOAD_HIGH = 8'h93;
  localparam logic [7:0] ADDR_COUNT_LOW = 8'h94;
  localparam logic [7:0] ADDR_COUNT_HIGH = 8'h95;
  // Reset values
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;
  // Control and status field positions
  localparam int BIT_HIGH_FLAG = 7;
  localparam int BIT_LOW_FLAG = 6;
  localparam int BIT_LOW_IRQ_EN = 5;
  localparam int BIT_CAPTURE_EN = 4;
  localparam int BIT_SPLIT = 3;
  localparam int BIT_RUN = 2;
  localparam int BIT_ALT_MSB = 1;
  localparam int BIT_ALT_LSB = 0;
  // Byte limits
  localparam logic [7:0] BYTE_MAX = 8'hFF;
  // Alternate clock select codes
  localparam logic [1:0] ALT_SYS_DIV = 2'h0;
  localparam logic [1:0] ALT_EXT_DIV = 2'h1;
  localparam logic [1:0] ALT_RESERVED = 2'h2;
  localparam logic [1:0] ALT_RTC = 2'h3;
  // Prescaler terminal counts
  localparam logic [3:0] SYS_DIV_LAST = 4'hB;
  localparam logic [2:0] EXT_DIV_LAST = 3'h7;
endpackage

// ---- testbench/tb_timer3_control_logic.sv ----
`timescale 1ns/100ps
module tb_timer3_control_logic;
  import timer3_pkg::*;
  logic clk = 1'h0, rst_n = 1'h0, wr = 1'h0, irq_en = 1'h1, hsel = 1'h1, lsel = 1'h1;
  logic ext = 1'h0, rtc = 1'h0, irq;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, rv;
  int n_fail = 0, checks = 0;
  timer3_control_logic dut (.i_clock(clk), .i_reset_n(rst_n), .i_sfr_addr(addr),
    .i_sfr_write(wr), .i_sfr_wdata(wdata), .o_sfr_rdata(rdata), .i_timer_irq_enable(irq_en),
    .i_high_byte_system_clock_select(hsel), .i_low_byte_system_clock_select(lsel), .i_ext_osc(ext),
    .i_rtc_osc(rtc), .o_timer_irq(irq));
  initial begin
    forever #5 clk = ~clk;
  end
  task check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  // One-cycle write strobe, launched just after an edge
  task wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 addr = a;
    wdata = d;
    wr = 1'h1;
    @(posedge clk);
    #1 wr = 1'h0;
  endtask
  // Read data lags the sampled address by one edge
  task rd(input logic [7:0] a);
    @(posedge clk);
    #1 addr = a;
    @(posedge clk);
    #1 rv = rdata;
  endtask
  task rd_chk(input logic [7:0] a, input logic [7:0] exp);
    rd(a);
    check(rv, exp);
  endtask
  task in_range(input logic [7:0] lo, input logic [7:0] hi);
    check({7'h00, rv >= lo && rv <= hi}, 8'h01);
  endtask
  task irq_chk(input logic e);
    @(posedge clk);
    #1 check({7'h00, irq}, {7'h00, e});
  endtask
  // Oscillator pulses, three cycles high and three low, slow enough to sync
  task pulse(input logic [1:0] m, input int n);
    for (int i = 0; i < n; i++) begin
      {ext, rtc} = m;
      repeat (3) @(posedge clk);
      #1 {ext, rtc} = 2'h0;
      repeat (3) @(posedge clk);
      #1;
    end
  endtask
  task t_reset;
    wr_reg(8'h90, 8'hAA);
    rd_chk(8'h90, READ_UNMAPPED);
    for (int a = 8'h91; a <= 8'h95; a++) rd_chk(8'(a), 8'h00);
    wr_reg(ADDR_RELOAD_LOW, 8'h5A);
    rd_chk(ADDR_RELOAD_LOW, 8'h5A);
    $display("reset test done");
  endtask
  task t_wrap16;
    wr_reg(ADDR_RELOAD_LOW, 8'h34);
    wr_reg(ADDR_RELOAD_HIGH, 8'h12);
    wr_reg(ADDR_COUNT_LOW, 8'hFE);
    wr_reg(ADDR_COUNT_HIGH, 8'hFF);
    wr_reg(ADDR_CONTROL_STATUS, 8'h04);
    repeat (3) @(posedge clk);
    rd_chk(ADDR_COUNT_HIGH, 8'h12);
    rd_chk(ADDR_CONTROL_STATUS, 8'hC4);
    irq_chk(1'h1);
    irq_en = 1'h0;
    irq_chk(1'h0);
    irq_en = 1'h1;
    repeat (20) @(posedge clk);
    rd_chk(ADDR_CONTROL_STATUS, 8'hC4);
    wr_reg(ADDR_CONTROL_STATUS, 8'h00);
    rd_chk(ADDR_CONTROL_STATUS, 8'h00);
    irq_chk(1'h0);
    rd(ADDR_COUNT_LOW);
    rd_chk(ADDR_COUNT_LOW, rv);
    $display("wrap test done");
  endtask
  task t_split;
    wr_reg(ADDR_RELOAD_LOW, 8'h10);
    wr_reg(ADDR_RELOAD_HIGH, 8'h20);
    wr_reg(ADDR_COUNT_LOW, 8'hFE);
    wr_reg(ADDR_COUNT_HIGH, 8'hFE);
    wr_reg(ADDR_CONTROL_STATUS, 8'h08);
    repeat (4) @(posedge clk);
    rd_chk(ADDR_CONTROL_STATUS, 8'h48);
    rd_chk(ADDR_COUNT_HIGH, 8'hFE);
    irq_chk(1'h0);
    wr_reg(ADDR_CONTROL_STATUS, 8'h68);
    irq_chk(1'h1);
    wr_reg(ADDR_CONTROL_STATUS, 8'h0C);
    repeat (4) @(posedge clk);
    rd(ADDR_COUNT_HIGH);
    in_range(8'h20, 8'h27);
    rd_chk(ADDR_CONTROL_STATUS, 8'h8C);
    wr_reg(ADDR_CONTROL_STATUS, 8'h00);
    $display("split test done");
  endtask
  // Alternate clock run from zero; the count reached shows the source
  task alt_case(input logic [1:0] c, input logic [1:0] m, input int n, input logic [7:0] lo,
    input logic [7:0] hi);
    wr_reg(ADDR_COUNT_LOW, 8'h00);
    wr_reg(ADDR_COUNT_HIGH, 8'h00);
    wr_reg(ADDR_CONTROL_STATUS, {5'h01, c});
    pulse(m, n);
    wr_reg(ADDR_CONTROL_STATUS, {6'h00, c});
    rd(ADDR_COUNT_LOW);
    in_range(lo, hi);
  endtask
  task t_alt;
    lsel = 1'h0;
    alt_case(ALT_SYS_DIV, 2'h1, 20, 8'h09, 8'h0B);
    alt_case(ALT_EXT_DIV, 2'h2, 16, 8'h02, 8'h02);
    alt_case(ALT_RTC, 2'h1, 5, 8'h05, 8'h05);
    alt_case(ALT_RESERVED, 2'h3, 8, 8'h00, 8'h00);
    lsel = 1'h1;
    // Split mode: high byte on the shared alternate clock, low byte on system clock
    hsel = 1'h0;
    wr_reg(ADDR_COUNT_HIGH, 8'h00);
    wr_reg(ADDR_CONTROL_STATUS, 8'h0F);
    pulse(2'h1, 5);
    wr_reg(ADDR_CONTROL_STATUS, 8'h0B);
    rd_chk(ADDR_COUNT_HIGH, 8'h05);
    wr_reg(ADDR_CONTROL_STATUS, 8'h00);
    hsel = 1'h1;
    $display("alternate clock test done");
  endtask
  task t_capture;
    wr_reg(ADDR_RELOAD_HIGH, 8'hFF);
    wr_reg(ADDR_COUNT_LOW, 8'h00);
    wr_reg(ADDR_COUNT_HIGH, 8'h00);
    wr_reg(ADDR_CONTROL_STATUS, 8'h14);
    rd_chk(ADDR_CONTROL_STATUS, 8'h14);
    pulse(2'h1, 1);
    rd_chk(ADDR_CONTROL_STATUS, 8'h94);
    rd_chk(ADDR_RELOAD_HIGH, 8'h00);
    rd(ADDR_RELOAD_LOW);
    in_range(8'h01, 8'h14);
    // Code 01: eight external edges give one capture, flag set again
    wr_reg(ADDR_CONTROL_STATUS, 8'h15);
    pulse(2'h2, 8);
    rd_chk(ADDR_CONTROL_STATUS, 8'h95);
    $display("capture test done");
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Whole run is a few hundred cycles; this bound only catches a hang
  initial begin
    #100000;
    n_fail++;
    end_of_test;
  end
  initial begin
    repeat (5) @(posedge clk);
    #1 rst_n = 1'h1;
    t_reset;
    t_wrap16;
    t_split;
    t_alt;
    t_capture;
    end_of_test;
  end
endmodule
bind timer3_control_logic timer3_checker chk (.i_clock(i_clock), .i_reset_n(i_reset_n),
  .i_sfr_addr(i_sfr_addr), .i_sfr_write(i_sfr_write), .i_sfr_wdata(i_sfr_wdata),
  .o_sfr_rdata(o_sfr_rdata), .i_timer_irq_enable(i_timer_irq_enable),
  .i_high_byte_system_clock_select(i_high_byte_system_clock_select),
  .i_low_byte_system_clock_select(i_low_byte_system_clock_select), .i_ext_osc(i_ext_osc),
  .i_rtc_osc(i_rtc_osc), .o_timer_irq(o_timer_irq));

// ---- testbench/timer3_checker_sva.sv ----
`timescale 1ns/100ps
module timer3_checker
  import timer3_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_write,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic [7:0] o_sfr_rdata,
  input wire logic i_timer_irq_enable,
  input wire logic i_high_byte_system_clock_select,
  input wire logic i_low_byte_system_clock_select,
  input wire logic i_ext_osc,
  input wire logic i_rtc_osc,
  input wire logic o_timer_irq
);
  logic [7:0] ctrl_ff; // Last control write
  logic [7:0] rl_ff; // Last reload low write
  logic rd_ok_ff; // Control read with no write
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  // Shadow of software writes; flags are not tracked, hardware sets them
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ctrl_ff <= 8'h00;
      rl_ff <= 8'h00;
      rd_ok_ff <= 1'h0;
    end else begin
      ctrl_ff <= (i_sfr_write && i_sfr_addr == ADDR_CONTROL_STATUS) ? i_sfr_wdata : ctrl_ff;
      rl_ff <= (i_sfr_write && i_sfr_addr == ADDR_RELOAD_LOW) ? i_sfr_wdata : rl_ff;
      rd_ok_ff <= i_sfr_addr == ADDR_CONTROL_STATUS && !i_sfr_write;
    end
  end
  irq_gate_a: assert property (o_timer_irq |-> i_timer_irq_enable)
    else $error("interrupt raised while masked");
  high_irq_a: assert property (rd_ok_ff && o_sfr_rdata[7] && i_timer_irq_enable
    |-> o_timer_irq)
    else $error("high flag set but no interrupt");
  low_irq_a: assert property (rd_ok_ff && (&o_sfr_rdata[6:5]) && i_timer_irq_enable
    |-> o_timer_irq)
    else $error("low flag enabled but no interrupt");
  high_hold_a: assert property (rd_ok_ff && o_sfr_rdata[7] && i_sfr_addr == ADDR_CONTROL_STATUS
    && !i_sfr_write |=> o_sfr_rdata[7])
    else $error("high flag cleared without a write");
  low_hold_a: assert property (rd_ok_ff && o_sfr_rdata[6] && i_sfr_addr == ADDR_CONTROL_STATUS
    && !i_sfr_write |=> o_sfr_rdata[6])
    else $error("low flag cleared without a write");
  ctrl_store_a: assert property ((i_sfr_write && i_sfr_addr == ADDR_CONTROL_STATUS) ##1
    (i_sfr_addr == ADDR_CONTROL_STATUS && !i_sfr_write) |=> o_sfr_rdata[5:0] == ctrl_ff[5:0])
    else $error("control bits not stored");
  reload_store_a: assert property ((i_sfr_write && i_sfr_addr == ADDR_RELOAD_LOW) ##1
    (i_sfr_addr == ADDR_RELOAD_LOW && !i_sfr_write && !ctrl_ff[4]) |=> o_sfr_rdata == rl_ff)
    else $error("reload low not stored");
  unmapped_read_a: assert property ((i_sfr_addr < ADDR_CONTROL_STATUS
    || i_sfr_addr > ADDR_COUNT_HIGH) |=> o_sfr_rdata == READ_UNMAPPED)
    else $error("unmapped address read nonzero");
endmodule
